// File: rtl/sbla_loader.sv
/*
 Boot loader sequencer: strap sampling, zero-byte baud measurement, identification byte,
 32-byte load into internal RAM, jump, and flash fetch redirection while loader mode holds.
 Assumes rst_n is the hardware reset, sw_reset a one-cycle software reset request,
 and that the RAM port and fetch inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sbla_loader #(
	parameter logic [7:0] ID_BYTE = 8'h3C, // arbitrary value
	parameter bit         ROMLESS = 1'b0
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        sw_reset,
	// straps
	input  wire logic        boot_select_pin,
	input  wire logic        external_access_select_n,
	// serial link
	input  wire logic        boot_serial_rx,
	output logic             boot_serial_tx,
	output logic             boot_serial_tx_oe,
	// internal RAM write port
	output logic             ram_we,
	output logic [15:0]      ram_addr,
	output logic [7:0]       ram_wdata,
	input  wire logic        ram_ready,
	// bytes received after the initial load
	output logic             app_rx_valid,
	output logic [7:0]       app_rx_data,
	input  wire logic        app_rx_ready,
	// program flow
	output logic             jump_req,
	output logic [23:0]      jump_addr,
	output logic [23:0]      reset_pc,
	output logic             exec_external,
	// fetch redirection
	input  wire logic        fetch_valid,
	input  wire logic        fetch_is_code,
	input  wire logic [23:0] fetch_addr,
	input  wire logic        flash_in_seg1,
	output logic             fetch_to_bootrom,
	output logic             data_undefined,
	// mode and status
	output logic             boot_loader_mode,
	output logic             watchdog_disable,
	output logic             flash_restricted,
	output logic [15:0]      baud_reload_value,
	output logic             baud_error,
	output logic             rx_overrun
);
	typedef struct packed {
		sbla_pkg::sbla_state_t st;
		logic [15:0]           brl;
		logic [15:0]           bitp;
		logic [1:0]            pre;
		logic [15:0]           tmr;
		logic                  ovf;
		logic                  err;
		logic [15:0]           cnt;
		logic [3:0]            idx;
		logic [7:0]            sh;
		logic                  rxon;
		logic                  orun;
		logic                  push;
		logic [7:0]            pdata;
		logic [5:0]            nrx;
		logic [5:0]            nwr;
		logic [15:0]           waddr;
		logic [9:0]            txsh;
		logic                  txoe;
		logic                  jump;
		logic                  ext;
	} sbla_regs_t;

	localparam sbla_regs_t REG_RST = '{
		st: sbla_pkg::ST_INIT, brl: '0, bitp: '0, pre: '0, tmr: '0, ovf: 1'b0, err: 1'b0,
		cnt: '0, idx: '0, sh: '0, rxon: 1'b0, orun: 1'b0, push: 1'b0, pdata: '0,
		nrx: '0, nwr: '0, waddr: sbla_pkg::LOAD_BASE, txsh: sbla_pkg::TX_IDLE,
		txoe: 1'b0, jump: 1'b0, ext: 1'b0};

	sbla_regs_t  r;
	sbla_regs_t  next_r;
	logic [15:0] brl_calc;
	logic [15:0] per_calc;
	logic        buf_in_ready;
	logic        buf_valid;
	logic [7:0]  buf_data;
	logic        buf_out_ready;
	logic        loading;
	logic        in_flash;
	logic        push_free;

	// truncating divide; a count below the offset yields reload zero
	assign brl_calc = (r.tmr >= sbla_pkg::MEAS_OFFSET) ?
		(r.tmr - sbla_pkg::MEAS_OFFSET) / sbla_pkg::MEAS_DIV : 16'h0000;
	// bit period in clocks is 32 times (reload + 1)
	assign per_calc = 16'((brl_calc + 16'h0001) << sbla_pkg::BAUD_SHIFT);

	// mode outputs
	assign boot_loader_mode  = !(r.st inside {sbla_pkg::ST_INIT, sbla_pkg::ST_NORMAL});
	assign watchdog_disable  = boot_loader_mode;
	assign flash_restricted  = boot_loader_mode;
	assign baud_reload_value = r.brl;
	assign baud_error        = r.err;
	assign rx_overrun        = r.orun;
	assign boot_serial_tx    = r.txsh[0];
	assign boot_serial_tx_oe = r.txoe;
	assign jump_req          = r.jump;
	assign jump_addr         = sbla_pkg::JUMP_ADDR;
	assign reset_pc          = sbla_pkg::RESET_PC;
	assign exec_external     = r.ext;

	// flash window follows the segment mapping
	assign in_flash = flash_in_seg1 ? (fetch_addr[23:15] == sbla_pkg::FLASH_SEG1) :
		(fetch_addr[23:15] == sbla_pkg::FLASH_SEG0);
	assign fetch_to_bootrom = boot_loader_mode && fetch_valid && fetch_is_code && in_flash;
	assign data_undefined   = boot_loader_mode && fetch_valid && !fetch_is_code && in_flash
		&& ROMLESS;

	// the first 32 bytes go to RAM, later ones to the application stream
	assign loading       = (r.nwr != sbla_pkg::LOAD_BYTES);
	assign ram_we        = buf_valid && loading;
	assign ram_addr      = r.waddr;
	assign ram_wdata     = buf_data;
	assign app_rx_valid  = buf_valid && !loading;
	assign app_rx_data   = buf_data;
	assign buf_out_ready = loading ? ram_ready : app_rx_ready;
	// a held byte may be replaced once the buffer takes it this cycle
	assign push_free     = !r.push || buf_in_ready;

	sbla_pair_buf #(
		.W (8)
	) u_buf (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (r.push),
		.in_data   (r.pdata),
		.in_ready  (buf_in_ready),
		.out_valid (buf_valid),
		.out_data  (buf_data),
		.out_ready (buf_out_ready)
	);

	// sequencer, baud measurement, transmitter and receiver
	always_comb begin
		next_r      = r;
		next_r.jump = 1'b0;
		if (r.push && buf_in_ready) begin
			next_r.push = 1'b0;
		end
		case (r.st)
			sbla_pkg::ST_INIT: begin
				// strap caught on the first edge after hardware reset
				if (boot_select_pin) begin
					next_r.st  = sbla_pkg::ST_NORMAL;
					next_r.ext = !external_access_select_n;
				end else begin
					next_r.st = sbla_pkg::ST_WAIT_HIGH;
				end
			end
			sbla_pkg::ST_NORMAL: begin
				next_r.st = sbla_pkg::ST_NORMAL;
			end
			sbla_pkg::ST_WAIT_HIGH: begin
				// a line held low from reset is not a start edge
				if (boot_serial_rx) begin
					next_r.st = sbla_pkg::ST_WAIT_START;
				end
			end
			sbla_pkg::ST_WAIT_START: begin
				if (!boot_serial_rx) begin
					next_r.st  = sbla_pkg::ST_MEASURE;
					next_r.pre = 2'h0;
					next_r.tmr = 16'h0000;
					next_r.ovf = 1'b0;
				end
			end
			sbla_pkg::ST_MEASURE: begin
				if (boot_serial_rx) begin
					if (r.ovf) begin
						// too slow a host: no usable setting, wait for a new zero byte
						next_r.err = 1'b1;
						next_r.st  = sbla_pkg::ST_WAIT_HIGH;
					end else begin
						next_r.err  = 1'b0;
						next_r.brl  = brl_calc;
						next_r.bitp = per_calc;
						next_r.st   = sbla_pkg::ST_TX_ID;
						next_r.txoe = 1'b1;
						next_r.txsh = {1'b1, ID_BYTE, 1'b0};
						next_r.idx  = 4'h0;
						next_r.cnt  = per_calc - 16'h0001;
					end
				end else begin
					// one count per four clocks over nine low bits
					next_r.pre = r.pre + 2'h1;
					if (r.pre == sbla_pkg::MEAS_PRE_LAST) begin
						if (r.tmr == sbla_pkg::MEAS_MAX) begin
							next_r.ovf = 1'b1;
						end else begin
							next_r.tmr = r.tmr + 16'h0001;
						end
					end
				end
			end
			sbla_pkg::ST_TX_ID: begin
				// identification frame at the derived rate
				if (r.cnt == 16'h0000) begin
					next_r.cnt  = r.bitp - 16'h0001;
					next_r.txsh = {1'b1, r.txsh[9:1]};
					next_r.idx  = r.idx + 4'h1;
					if (r.idx == sbla_pkg::FRAME_LAST) begin
						next_r.st  = sbla_pkg::ST_LOAD;
						next_r.idx = 4'h0;
					end
				end else begin
					next_r.cnt = r.cnt - 16'h0001;
				end
			end
			sbla_pkg::ST_LOAD, sbla_pkg::ST_RUN: begin
				// receiver keeps the measured rate for later loaded code
				if (!r.rxon) begin
					if (!boot_serial_rx) begin
						next_r.rxon = 1'b1;
						next_r.cnt  = {1'b0, r.bitp[15:1]};
						next_r.idx  = 4'h0;
					end
				end else if (r.cnt != 16'h0000) begin
					next_r.cnt = r.cnt - 16'h0001;
				end else begin
					next_r.cnt = r.bitp - 16'h0001;
					next_r.idx = r.idx + 4'h1;
					if (r.idx == 4'h0) begin
						// a start bit gone high at mid-bit was a glitch
						if (boot_serial_rx) begin
							next_r.rxon = 1'b0;
						end
					end else if (r.idx <= sbla_pkg::DATA_LAST) begin
						next_r.sh = {boot_serial_rx, r.sh[7:1]};
					end else begin
						next_r.rxon = 1'b0;
						// framing errors drop the byte and do not count
						if (boot_serial_rx) begin
							if (!push_free) begin
								next_r.orun = 1'b1;
							end else begin
								next_r.push  = 1'b1;
								next_r.pdata = r.sh;
							end
							if (r.st == sbla_pkg::ST_LOAD) begin
								next_r.nrx = r.nrx + 6'h01;
								if (r.nrx == sbla_pkg::LOAD_LASTIDX) begin
									next_r.st = sbla_pkg::ST_RUN;
								end
							end
						end
					end
				end
			end
			default: begin
				next_r.st = sbla_pkg::ST_INIT;
			end
		endcase
		// RAM writes in arrival order, jump after the last one
		if (ram_we && ram_ready) begin
			next_r.nwr   = r.nwr + 6'h01;
			next_r.waddr = r.waddr + 16'h0001;
			if (r.nwr == sbla_pkg::LOAD_LASTIDX) begin
				next_r.jump = 1'b1;
			end
		end
		// software reset ends loader mode whatever the strap
		if (sw_reset) begin
			next_r     = REG_RST;
			next_r.st  = sbla_pkg::ST_NORMAL;
			next_r.ext = !external_access_select_n;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= REG_RST;
		end else begin
			r <= next_r;
		end
	end

	// checks on the sequencer
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_strap;
		(r.st == sbla_pkg::ST_INIT) && boot_select_pin |=> !boot_loader_mode;
	endproperty
	a_strap: assert property (p_strap) else $error("loader entered with strap high");

	property p_zero_start;
		(r.st == sbla_pkg::ST_WAIT_START) && !boot_serial_rx && !sw_reset
			|=> (r.st == sbla_pkg::ST_MEASURE) && (r.tmr == 16'h0000);
	endproperty
	a_zero_start: assert property (p_zero_start) else $error("start edge missed");

	property p_tx_start;
		$rose(r.st == sbla_pkg::ST_TX_ID) |-> !boot_serial_tx && boot_serial_tx_oe;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("id frame lacks start bit");

	property p_rx_after;
		(r.st == sbla_pkg::ST_TX_ID) |-> !r.rxon && (r.nrx == 6'h00);
	endproperty
	a_rx_after: assert property (p_rx_after) else $error("receiver on during id");

	property p_window;
		ram_we |-> (ram_addr == 16'(sbla_pkg::LOAD_BASE + 16'(r.nwr)))
			&& (ram_addr <= sbla_pkg::LOAD_LAST);
	endproperty
	a_window: assert property (p_window) else $error("write outside window");

	property p_jump;
		jump_req |-> (r.nwr == sbla_pkg::LOAD_BYTES) && (jump_addr == sbla_pkg::JUMP_ADDR)
			&& $past(ram_we && ram_ready);
	endproperty
	a_jump: assert property (p_jump) else $error("jump not after last write");

	property p_stay;
		jump_req && !sw_reset |=> boot_loader_mode && watchdog_disable;
	endproperty
	a_stay: assert property (p_stay) else $error("loader left after jump");

	property p_sw_exit;
		sw_reset |=> !boot_loader_mode [*2];
	endproperty
	a_sw_exit: assert property (p_sw_exit) else $error("soft reset kept loader");

	property p_fetch;
		boot_loader_mode && fetch_valid && fetch_is_code && !flash_in_seg1
			&& (fetch_addr <= 24'h007FFF) |-> fetch_to_bootrom;
	endproperty
	a_fetch: assert property (p_fetch) else $error("flash fetch not redirected");

	property p_period;
		(r.st == sbla_pkg::ST_TX_ID) |-> (32'(r.bitp) == 32 * (32'(r.brl) + 1));
	endproperty
	a_period: assert property (p_period) else $error("bit period mismatch");

	property p_reload;
		(r.st == sbla_pkg::ST_MEASURE) && boot_serial_rx && !r.ovf && !sw_reset
			&& (r.tmr >= sbla_pkg::MEAS_OFFSET)
			|=> (72 * 32'(r.brl) + 36 <= 32'($past(r.tmr)))
			&& (32'($past(r.tmr)) < 72 * 32'(r.brl) + 108);
	endproperty
	a_reload: assert property (p_reload) else $error("reload value wrong");

	c_jump: cover property (jump_req);
	c_baud_err: cover property ($rose(baud_error));
	c_app_byte: cover property (app_rx_valid && app_rx_ready);
	c_ram_stall: cover property (ram_we && !ram_ready);
endmodule
`default_nettype wire

// File: rtl/sbla_pkg.sv
/*
 Shared constants and types of the serial boot loader with automatic baud detection.
 Assumes a single CPU clock domain; the user includes nothing, every use is scoped.
*/
package sbla_pkg;
	// clock rate of the block
	localparam int          CLK_HZ        = 10000000;
	// internal RAM loading window and jump target
	localparam logic [15:0] LOAD_BASE     = 16'hFA40;
	localparam logic [15:0] LOAD_LAST     = 16'hFA5F;
	localparam logic [5:0]  LOAD_BYTES    = 6'h20;
	localparam logic [5:0]  LOAD_LASTIDX  = 6'h1F;
	localparam logic [23:0] JUMP_ADDR     = 24'h00FA40;
	localparam logic [23:0] RESET_PC      = 24'h000000;
	// reload computation: (count - offset) / divisor
	localparam logic [15:0] MEAS_OFFSET   = 16'h0024;
	localparam logic [15:0] MEAS_DIV      = 16'h0048;
	localparam logic [15:0] MEAS_MAX      = 16'hFFFF;
	localparam logic [1:0]  MEAS_PRE_LAST = 2'h3;
	// bit period in clocks is (reload + 1) shifted by this amount, i.e. times 32
	localparam int          BAUD_SHIFT    = 5;
	// frame layout: index 0 start, 1..8 data, 9 stop
	localparam logic [3:0]  FRAME_LAST    = 4'h9;
	localparam logic [3:0]  DATA_LAST     = 4'h8;
	localparam logic [9:0]  TX_IDLE       = 10'h3FF;
	// flash window tags, address bits 23..15
	localparam logic [8:0]  FLASH_SEG0    = 9'h000;
	localparam logic [8:0]  FLASH_SEG1    = 9'h002;

	// sequencer states, one-hot
	typedef enum logic [7:0] {
		ST_INIT       = 8'h01,
		ST_NORMAL     = 8'h02,
		ST_WAIT_HIGH  = 8'h04,
		ST_WAIT_START = 8'h08,
		ST_MEASURE    = 8'h10,
		ST_TX_ID      = 8'h20,
		ST_LOAD       = 8'h40,
		ST_RUN        = 8'h80
	} sbla_state_t;
endpackage

// File: rtl/sbla_pair_buf.sv
/*
 Two-entry valid/ready buffer carrying received bytes toward RAM or the application.
 Assumes the filler honours in_ready and the drain may stall at any time.
*/
`timescale 1ns/1ps
`default_nettype none
module sbla_pair_buf #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// filling side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// draining side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	typedef struct packed {
		logic [W-1:0] d0;
		logic [W-1:0] d1;
		logic [1:0]   cnt;
	} sbla_buf_t;

	sbla_buf_t r;
	sbla_buf_t next_r;
	logic      push;
	logic      pop;

	// full at two entries, so a stalled drain pushes back on the filler
	assign in_ready  = (r.cnt != 2'h2);
	assign out_valid = (r.cnt != 2'h0);
	assign out_data  = r.d0;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// entry 0 is always the head
	always_comb begin
		next_r = r;
		if (pop) begin
			next_r.d0  = r.d1;
			next_r.cnt = r.cnt - 2'h1;
		end
		if (push) begin
			if (next_r.cnt == 2'h0) begin
				next_r.d0 = in_data;
			end else begin
				next_r.d1 = in_data;
			end
			next_r.cnt = next_r.cnt + 2'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule
`default_nettype wire

// File: test/sbla_host_model.sv
/*
 Host side of the boot link: sends asynchronous frames and listens for the device's answer.
 Assumes one clock shared with the bench; the host line idles high between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module sbla_host_model #(
	parameter int BIT_CLKS = 64
) (
	// clock
	input  wire logic clk,
	// serial wires
	output var logic  host_tx,
	input  wire logic dev_tx
);
	// an asynchronous line rests at mark level, so the host keeps it high
	initial host_tx = 1'b1;

	// one frame, LSB first: start low, eight data bits, stop high
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			host_tx <= fr[i];
			repeat (BIT_CLKS - 1) @(posedge clk);
		end
	endtask

	// sample the device frame at mid-bit; ok is low on a missing start or stop
	task automatic recv_byte(input int bitp, output logic [7:0] b, output logic ok);
		int n;
		ok = 1'b0;
		b = 8'h00;
		n = 0;
		while (dev_tx !== 1'b0 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n < 20000) begin
			repeat (bitp / 2) @(posedge clk);
			ok = (dev_tx === 1'b0);
			for (int i = 0; i < 8; i++) begin
				repeat (bitp) @(posedge clk);
				b[i] = dev_tx;
			end
			repeat (bitp) @(posedge clk);
			ok = ok && (dev_tx === 1'b1);
		end
	endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
/*
 Self-checking bench of the serial boot loader: entry, baud measurement, load, jump,
 fetch redirection, later reception through the buffer, and both ways out of loader mode.
 Assumes the host model of this folder and a RAM that stalls one cycle in four.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [7:0]  ID       = 8'hA7; // arbitrary value
	// host rate matches the device rate exactly, far from timer overflow
	localparam int          HOST_BIT = 64;
	localparam logic [15:0] EXP_RLD  = 16'(((9 * HOST_BIT / 4) - 36) / 72);
	localparam int          DEV_BIT  = 32 * (int'(EXP_RLD) + 1);

	logic        clk, rst_n, sw_reset, boot_select_pin, external_access_select_n;
	logic        boot_serial_rx, boot_serial_tx, boot_serial_tx_oe;
	logic        ram_we, app_rx_valid, app_rx_ready, jump_req, exec_external;
	logic        fetch_valid, fetch_is_code, flash_in_seg1, fetch_to_bootrom, data_undefined;
	logic        boot_loader_mode, watchdog_disable, flash_restricted, baud_error, rx_overrun;
	logic [15:0] ram_addr, baud_reload_value;
	logic [7:0]  ram_wdata, app_rx_data, b;
	logic [23:0] jump_addr, reset_pc, fetch_addr;
	logic [3:0]  cyc = 4'h0;
	logic        ok;
	logic [15:0] wa[$];
	logic [7:0]  wd[$];
	logic [7:0]  ad[$];
	int          n_jump = 0;
	int          n_fail = 0;
	int          n_tests = 0;
	wire         ram_ready = (cyc[1:0] != 2'h0);

	sbla_loader #(.ID_BYTE(ID), .ROMLESS(1'b1)) uut (
		.clk, .rst_n, .sw_reset, .boot_select_pin, .external_access_select_n,
		.boot_serial_rx, .boot_serial_tx, .boot_serial_tx_oe,
		.ram_we, .ram_addr, .ram_wdata, .ram_ready,
		.app_rx_valid, .app_rx_data, .app_rx_ready,
		.jump_req, .jump_addr, .reset_pc, .exec_external,
		.fetch_valid, .fetch_is_code, .fetch_addr, .flash_in_seg1,
		.fetch_to_bootrom, .data_undefined,
		.boot_loader_mode, .watchdog_disable, .flash_restricted,
		.baud_reload_value, .baud_error, .rx_overrun
	);

	sbla_host_model #(.BIT_CLKS(HOST_BIT)) host (
		.clk(clk),
		.host_tx(boot_serial_rx),
		.dev_tx(boot_serial_tx)
	);

	// 10 MHz clock
	always #50 clk = ~clk;

	// RAM and application sinks log every accepted transfer and every jump cycle
	always @(posedge clk) begin
		cyc <= cyc + 4'h1;
		if (ram_we === 1'b1 && ram_ready === 1'b1) begin
			wa.push_back(ram_addr);
			wd.push_back(ram_wdata);
		end
		if (app_rx_valid === 1'b1 && app_rx_ready === 1'b1)
			ad.push_back(app_rx_data);
		if (jump_req === 1'b1)
			n_jump++;
	end

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (n_fail == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic hw_reset(input logic sel);
		@(posedge clk);
		rst_n <= 1'b0;
		boot_select_pin <= sel;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	function automatic logic [7:0] pat(input int k);
		return 8'(k * 37 + 5);
	endfunction

	// flags read as mode, watchdog off, flash restricted, transmitter disabled with the line idle high
	task automatic t_entry();
		hw_reset(1'b0);
		check(24'({boot_loader_mode, watchdog_disable, flash_restricted}), 24'h000007);
		check(24'({boot_serial_tx_oe, boot_serial_tx}), 24'h000001);
	endtask

	// a frame sent while the id byte goes out must not be stored
	task automatic t_baud();
		fork
			begin
				host.send_byte(8'h00);
				host.send_byte(8'hF0);
			end
			host.recv_byte(DEV_BIT, b, ok);
		join
		check(24'(baud_reload_value), 24'(EXP_RLD));
		check(24'({ok, b}), 24'({1'b1, ID}));
		check(24'({boot_serial_tx_oe, baud_error}), 24'h000002);
		check(24'(wa.size()), 24'h000000);
	endtask

	task automatic t_load();
		int n;
		for (int k = 0; k < 32; k++)
			host.send_byte(pat(k));
		n = 0;
		while (n_jump == 0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n == 3000) begin
			n_fail++;
			give_verdict();
		end
		repeat (4) @(posedge clk);
		check(24'(wa.size()), 24'h000020);
		for (int k = 0; k < 32; k++) begin
			check(24'({wa[k], wd[k]}), 24'({16'(16'hFA40 + k), pat(k)}));
		end
		check(24'(n_jump), 24'h000001);
		check(jump_addr, 24'h00FA40);
		check(24'({boot_loader_mode, watchdog_disable, flash_restricted}), 24'h000007);
	endtask

	// entries: valid, code fetch, segment 1 mapping, expected redirect, expected undefined,
	// address; the bench part has no program memory, so flash data reads are undefined
	task automatic t_fetch();
		logic [28:0] tbl[10];
		tbl = '{{5'h1A, 24'h000000}, {5'h1A, 24'h007FFF}, {5'h18, 24'h008000},
			{5'h18, 24'h010000}, {5'h1E, 24'h010000}, {5'h1E, 24'h017FFF},
			{5'h1C, 24'h018000}, {5'h11, 24'h000100}, {5'h15, 24'h010000},
			{5'h08, 24'h000000}};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			fetch_valid <= tbl[i][28];
			fetch_is_code <= tbl[i][27];
			flash_in_seg1 <= tbl[i][26];
			fetch_addr <= tbl[i][23:0];
			@(negedge clk);
			check(24'({fetch_to_bootrom, data_undefined}), 24'(tbl[i][25:24]));
		end
	endtask

	// stalled sink: three words fit, the fourth overruns
	task automatic t_app();
		host.send_byte(8'h5A);
		host.send_byte(8'hC3);
		host.send_byte(8'h0F);
		repeat (20) @(posedge clk);
		check(24'({app_rx_valid, rx_overrun}), 24'h000002);
		app_rx_ready <= 1'b1;
		repeat (10) @(posedge clk);
		app_rx_ready <= 1'b0;
		check(24'({ad.size(), ad[0], ad[1], ad[2]}), 24'h5AC30F);
		check(24'(ad.size()), 24'h000003);
		check(24'(baud_reload_value), 24'(EXP_RLD));
		for (int k = 0; k < 4; k++)
			host.send_byte(pat(k));
		repeat (20) @(posedge clk);
		check(24'(rx_overrun), 24'h000001);
	endtask

	// software reset with the strap still low, then the two hardware cases
	task automatic t_exit();
		@(posedge clk);
		external_access_select_n <= 1'b0;
		fetch_valid <= 1'b1;
		fetch_addr <= 24'h000000;
		fetch_is_code <= 1'b1;
		flash_in_seg1 <= 1'b0;
		sw_reset <= 1'b1;
		@(posedge clk);
		sw_reset <= 1'b0;
		repeat (3) @(posedge clk);
		check(24'({boot_loader_mode, watchdog_disable, fetch_to_bootrom}), 24'h000000);
		check(24'({reset_pc, exec_external}), 24'h000001);
		hw_reset(1'b0);
		check(24'(boot_loader_mode), 24'h000001);
		check(24'({boot_loader_mode, fetch_to_bootrom}), 24'h000003);
		external_access_select_n <= 1'b1;
		hw_reset(1'b1);
		check(24'({boot_loader_mode, exec_external}), 24'h000000);
		check(reset_pc, 24'h000000);
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		sw_reset = 1'b0;
		boot_select_pin = 1'b0;
		external_access_select_n = 1'b1;
		app_rx_ready = 1'b0;
		fetch_valid = 1'b0;
		fetch_is_code = 1'b0;
		fetch_addr = 24'h000000;
		flash_in_seg1 = 1'b0;
		t_entry();
		t_baud();
		t_load();
		t_fetch();
		t_app();
		t_exit();
		give_verdict();
	end
endmodule
`default_nettype wire
